// ==== design/jtfs_framer.sv ====
`timescale 1ns/1ps
`include "jtfs_cfg.svh"
module jtfs_framer
	import jtfs_pkg::*;
(
	input  logic                  hclk,
	input  logic                  hresetn,
	input  logic                  hsel,
	input  logic [31:0]           haddr,
	input  logic [1:0]            htrans,
	input  logic                  hwrite,
	input  logic [2:0]            hsize,
	input  logic [31:0]           hwdata,
	input  logic                  hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	input  logic [3:0][3:0][15:0] conv_sample,
	output logic                  sample_take,
	jtfs_link_if.framer           link
);
	// Software registers
	logic [4:0]      ctrl;      // Link enable, pattern enable, order
	logic [11:0]     frame;     // Layout logs and frames per multiframe
	logic [6:0]      serdes;    // Emphasis and swing
	logic [15:0]     xbar;      // Sample and lane crossbars
	// Bus data-phase state
	logic            wr_pend;   // Write data due this cycle
	logic            rd_pend;   // Read data due this cycle
	logic [7:0]      dp_addr;   // Captured offset
	// Framer state
	jtfs_link_e      state;     // Bring-up phase
	logic [1:0]      mf;        // Multiframe count in ILAS
	logic [2:0]      pos;       // Octet within frame
	logic [5:0]      fcnt;      // Frame within multiframe
	logic [3:0][3:0][15:0] smp; // Frame of samples being sent
	logic [3:0][7:0] prev;      // Last octet of previous frame
	logic [3:0]      rd;        // Running disparity per framer lane
	logic [3:0][9:0] fsym;      // Encoded framer lane symbols
	logic [3:0][9:0] sym;       // Symbols on the serial lanes
	logic [3:0][9:0] boost;     // Emphasis flags per bit
	logic [30:0]     pst;       // Pattern shift register
	logic [40:0]     pnext;     // Pattern step result
	// Layout decode
	logic [1:0]      mlog, llog, slog, flog;
	logic [3:0]      fsum;      // log2 of 2*M*S
	logic [5:0]      kfr;       // Frames per multiframe
	logic [9:0]      fk;        // Octets per multiframe
	logic [2:0]      fmax;      // Last octet index of a frame
	logic            cfg_bad;   // Layout or multiframe illegal
	logic            frame_end;
	logic            mf_end;
	logic            acc;       // Address phase accepted

	assign mlog = frame[1:0];
	assign llog = frame[3:2];
	assign slog = frame[5:4];
	assign kfr  = frame[11:6];
	assign fsum = 4'h1 + {2'h0, mlog} + {2'h0, slog};
	// F = 2^(1+mlog+slog-llog), only 1..8 supported
	assign flog = 2'(fsum - {2'h0, llog}); // RULE18
	assign fk   = 10'({4'h0, kfr} << flog);
	assign fmax = 3'((4'h1 << flog) - 4'h1);
	// Illegal layouts hold the link in CGS
	assign cfg_bad = (fsum < {2'h0, llog}) || (fsum - {2'h0, llog} > 4'h3) ||
		(mlog == 2'h3) || (llog == 2'h3) || (slog == 2'h3) ||
		(fk < `JTFS_FK_MIN) || (fk > `JTFS_FK_MAX) || (fk[1:0] != 2'h0); // RULE19
	assign frame_end = (pos >= fmax);
	assign mf_end    = frame_end && (fcnt >= kfr - 6'h01);

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc       = hsel && hready && htrans[1];

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			wr_pend <= acc && hwrite;
			rd_pend <= acc && !hwrite;
			if (acc) begin
				dp_addr <= haddr[7:0];
			end
		end
	end

	// Register writes in data phase; status is read-only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl   <= `JTFS_CTRL_RST;
			frame  <= `JTFS_FRAME_RST;
			serdes <= `JTFS_SERDES_RST; // RULE1
			xbar   <= `JTFS_XBAR_RST;
		end else if (wr_pend) begin
			case (dp_addr)
				`JTFS_ADDR_CTRL:   ctrl   <= hwdata[4:0];
				`JTFS_ADDR_FRAME:  frame  <= hwdata[11:0];
				`JTFS_ADDR_SERDES: serdes <= hwdata[6:0]; // RULE1 RULE3
				`JTFS_ADDR_XBAR:   xbar   <= hwdata[15:0];
				default: ;         // Unmapped writes dropped
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend) begin
			case (dp_addr)
				`JTFS_ADDR_CTRL:   hrdata = {27'h0, ctrl};
				`JTFS_ADDR_FRAME:  hrdata = {20'h0, frame};
				`JTFS_ADDR_SERDES: hrdata = {25'h0, serdes};
				`JTFS_ADDR_XBAR:   hrdata = {16'h0, xbar};
				`JTFS_ADDR_STATUS: hrdata = {28'h0, link.sync_n, cfg_bad, state};
				default:           hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Octet and frame counters run in every phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos  <= 3'h0;
			fcnt <= 6'h00;
		end else if (frame_end) begin
			pos  <= 3'h0;
			fcnt <= mf_end ? 6'h00 : fcnt + 6'h01;
		end else begin
			pos  <= pos + 3'h1;
		end
	end

	// Bring-up sequencer, phases advance only on multiframe ends, fall back to CGS at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= LS_CGS;
			mf    <= 2'h0;
		end else begin
			case (state)
				LS_CGS: begin
					mf <= 2'h0;
					if (ctrl[`JTFS_CTRL_LINK_EN] && !cfg_bad && link.sync_n && mf_end) begin
						state <= LS_ILAS; // RULE7
					end
				end
				LS_ILAS: begin
					if (!ctrl[`JTFS_CTRL_LINK_EN] || !link.sync_n || cfg_bad) begin
						state <= LS_CGS;
					end else if (mf_end) begin
						mf <= mf + 2'h1;
						if (mf == `JTFS_ILAS_MF) begin
							state <= LS_DATA; // RULE7
						end
					end
				end
				LS_DATA: begin
					if (!ctrl[`JTFS_CTRL_LINK_EN] || !link.sync_n || cfg_bad) begin
						state <= LS_CGS; // RULE7
					end
				end
				default: state <= LS_CGS;
			endcase
		end
	end

	// Next frame is taken while the last octet of this one goes out
	assign sample_take = frame_end;

	// Per converter slot: pick source converter, latch at frame end
	for (genvar m = 0; m < 4; m++) begin : g_slot
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				smp[m] <= '0;
			end else if (frame_end) begin
				smp[m] <= conv_sample[xbar[8 + 2 * m +: 2]]; // RULE5 RULE10
			end
		end
	end

	// Per framer lane: pack, replace, encode
	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [5:0]  idx;  // Octet number within the frame
		logic [4:0]  q;    // Sample number, converter-major
		logic [1:0]  cv;   // Converter of that sample
		logic [1:0]  sn;   // Sample within converter
		logic [15:0] word;
		logic [7:0]  dat;  // Transport data octet
		logic [7:0]  oct;  // Octet after control insertion
		logic        k;
		logic [10:0] enc;

		// Lane l carries octets l*F .. l*F+F-1, MSB octet first
		assign idx  = 6'({3'h0, 3'(l)} << flog) + {3'h0, pos}; // RULE6 RULE12
		assign q    = idx[5:1];
		assign cv   = 2'(q >> slog);
		assign sn   = 2'(q) & 2'((3'h1 << slog) - 3'h1);
		assign word = smp[cv][sn];
		assign dat  = idx[0] ? word[7:0] : word[15:8]; // RULE12

		// Control characters by phase
		always_comb begin
			oct = dat;
			k   = 1'b0;
			case (state)
				LS_CGS: begin
					oct = `JTFS_K_K;
					k   = 1'b1;
				end
				LS_ILAS: begin
					k = 1'b1;
					if (fcnt == 6'h00 && pos == 3'h0) begin
						oct = `JTFS_K_R;
					end else if (mf_end) begin
						oct = `JTFS_K_A;
					end else if (mf == 2'h1 && fcnt == 6'h00 && pos == 3'h1) begin
						oct = `JTFS_K_Q;
					end else begin
						oct = {fcnt[4:0], pos}; // Ramp stands in for config data
						k   = 1'b0;
					end
				end
				LS_DATA: begin
					// Repeat of last frame's end octet is replaced
					if (frame_end && dat == prev[l]) begin
						oct = mf_end ? `JTFS_K_A : `JTFS_K_F; // RULE8
						k   = 1'b1;
					end
				end
				default: ;
			endcase
		end

		assign enc     = jtfs_enc(oct, k, rd[l]); // RULE9
		assign fsym[l] = enc[9:0];

		// Disparity and frame-end history
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				rd[l]   <= 1'b0;
				prev[l] <= 8'h00;
			end else begin
				rd[l] <= enc[10];
				if (frame_end) begin
					prev[l] <= (state == LS_DATA) ? dat : 8'h00; // RULE8
				end
			end
		end
	end

	// Free-running pattern source
	assign pnext = jtfs_prbs(pst, ctrl[`JTFS_CTRL_SEL_LSB +: 3]); // RULE13 RULE20
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pst <= 31'h7FFF_FFFF;
		end else begin
			pst <= pnext[40:10];
		end
	end

	// Serial lanes: crossbar, pattern injection, emphasis
	for (genvar p = 0; p < 4; p++) begin : g_ser
		logic [9:0] nsym;
		logic [9:0] nb;
		// Pattern overrides the framer whatever the link state
		assign nsym = ctrl[`JTFS_CTRL_PRBS_EN] ? pnext[9:0] :
			fsym[xbar[2 * p +: 2]]; // RULE11 RULE14 RULE15
		// Boost flags each bit differing from the one before
		always_comb begin
			nb    = 10'h000;
			nb[9] = (serdes[6:4] != 3'h0) && (nsym[9] != sym[p][0]); // RULE4
			for (int i = 0; i < 9; i++) begin
				nb[i] = (serdes[6:4] != 3'h0) && (nsym[i] != nsym[i + 1]); // RULE4
			end
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				sym[p]   <= 10'h000;
				boost[p] <= 10'h000;
			end else begin
				sym[p]   <= nsym;
				boost[p] <= nb;
			end
		end
	end

	// Analog settings go straight to the drivers
	assign link.sym   = sym;
	assign link.boost = boost;
	assign link.swing = serdes[3:0]; // RULE1
	assign link.emph  = serdes[6:4]; // RULE3
endmodule // jtfs_framer

// ==== design/jtfs_cfg.svh ====
// Functional notes
// [RULE1] Four-bit swing setting, resets to fifteen
// [RULE2] Software keeps swing between twelve and fifteen
// [RULE3] Three-bit emphasis setting drives serializer boost
// [RULE4] Boost changed bits, de-emphasize repeated bits
// [RULE5] Framer input words are 16-bit samples
// [RULE6] Lane layout follows lanes, converters, samples
// [RULE7] Link goes CGS, then ILAS, then data
// [RULE8] Replace frame and multiframe end octets
// [RULE9] Every lane octet is 8B10B encoded
// [RULE10] Sample crossbar places any converter anywhere
// [RULE11] Lane crossbar maps framer to serial lanes
// [RULE12] Standard transport layer octet packing order
// [RULE13] Pattern generator offers five PRBS orders
// [RULE14] Pattern runs regardless of sync or errors
// [RULE15] Pattern order chosen, injected at serializer
// [RULE16] Pattern test only after link initialization
// [RULE17] Checker enabled, cleared, waited, then read
// [RULE18] Frame octets equal 2*M*S/L
// [RULE19] F*K within 20..256, multiple of four
// [RULE20] Customary polynomial per order, free-running LFSR
`ifndef JTFS_CFG_SVH
`define JTFS_CFG_SVH
// Register byte offsets
`define JTFS_ADDR_CTRL    8'h00
`define JTFS_ADDR_FRAME   8'h04
`define JTFS_ADDR_SERDES  8'h08
`define JTFS_ADDR_XBAR    8'h0C
`define JTFS_ADDR_STATUS  8'h10
// Control fields
`define JTFS_CTRL_LINK_EN 0
`define JTFS_CTRL_PRBS_EN 1
`define JTFS_CTRL_SEL_LSB 2
// Reset values
`define JTFS_CTRL_RST     5'h00
`define JTFS_FRAME_RST    12'h801
`define JTFS_SERDES_RST   7'h0F
`define JTFS_XBAR_RST     16'hE4E4
// Control characters
`define JTFS_K_R          8'h1C
`define JTFS_K_A          8'h7C
`define JTFS_K_Q          8'h9C
`define JTFS_K_K          8'hBC
`define JTFS_K_F          8'hFC
// Link counts and limits
`define JTFS_ILAS_MF      2'h3
`define JTFS_CGS_LOCK     3'h4
`define JTFS_A_COUNT      3'h4
`define JTFS_FK_MIN       10'h014
`define JTFS_FK_MAX       10'h100
`define JTFS_SWING_MIN    4'hC
`endif

// ==== design/jtfs_pkg.sv ====
package jtfs_pkg;
	// Link bring-up phases
	typedef enum logic [1:0] {LS_CGS, LS_ILAS, LS_DATA} jtfs_link_e;

	// 5b/6b codes for negative disparity, bit a first
	localparam logic [5:0] JTFS_T6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	// 3b/4b codes for negative disparity, bit f first
	localparam logic [3:0] JTFS_T4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	// 8B10B encode; only K28.y control codes; returns {rd_out, abcdeifghj}
	function automatic logic [10:0] jtfs_enc(input logic [7:0] d, input logic k,
			input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic       r;
		logic       alt;
		c6 = k ? 6'h0F : JTFS_T6[d[4:0]];
		if (rd && ($countones(c6) != 3 || c6 == 6'h38)) begin
			c6 = ~c6;
		end
		r   = ($countones(c6) != 3) ? ~rd : rd;
		alt = (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
			(r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E));
		c4  = (d[7:5] == 3'h7 && (k || alt)) ? 4'h7 : JTFS_T4[d[7:5]];
		if (r && ($countones(c4) != 2 || c4 == 4'hC)) begin
			c4 = ~c4;
		end else if (k && !r && $countones(c4) == 2 && c4 != 4'hC) begin
			c4 = ~c4; // Balanced K28 tails run inverted
		end
		return {(($countones(c4) != 2) ? ~r : r), c6, c4};
	endfunction

	// Tap pair of the selected order, newest bit at index zero
	function automatic logic [9:0] jtfs_taps(input logic [2:0] sel);
		case (sel)
			3'h0:    return {5'd6, 5'd5};   // x^7+x^6+1
			3'h1:    return {5'd8, 5'd4};   // x^9+x^5+1
			3'h2:    return {5'd14, 5'd13}; // x^15+x^14+1
			3'h3:    return {5'd22, 5'd17}; // x^23+x^18+1
			default: return {5'd30, 5'd27}; // x^31+x^28+1
		endcase
	endfunction

	// Ten pattern bits per clock, first bit in position nine
	function automatic logic [40:0] jtfs_prbs(input logic [30:0] st, input logic [2:0] sel);
		logic [30:0] s;
		logic [9:0]  b;
		logic [9:0]  t;
		s = st;
		b = 10'h000;
		t = jtfs_taps(sel);
		for (int i = 9; i >= 0; i--) begin
			b[i] = s[t[9:5]] ^ s[t[4:0]];
			s    = {s[29:0], b[i]};
		end
		return {s, b};
	endfunction
endpackage

// ==== design/jtfs_link_if.sv ====
`timescale 1ns/1ps
interface jtfs_link_if;
	logic [3:0][9:0] sym;    // Serial symbols, bit 9 sent first
	logic [3:0][9:0] boost;  // Emphasis boost per bit
	logic [3:0]      swing;  // Output swing setting
	logic [2:0]      emph;   // Emphasis strength
	logic            sync_n; // Receiver sync request, low asks CGS
	modport framer (output sym, output boost, output swing, output emph, input sync_n);
	modport deframer (input sym, input boost, input swing, input emph, output sync_n);
endinterface

// ==== design/jtfs_deframer.sv ====
`timescale 1ns/1ps
`include "jtfs_cfg.svh"
module jtfs_deframer
	import jtfs_pkg::*;
(
	input  logic                 hclk,
	input  logic                 hresetn,
	jtfs_link_if.deframer        link,
	input  logic                 link_req,
	input  logic [1:0]           cfg_flog,
	input  logic [5:0]           cfg_k,
	input  logic                 chk_en,
	input  logic                 chk_clear,
	input  logic [2:0]           chk_sel,
	output logic [3:0][7:0]      rx_octet,
	output logic [3:0]           rx_is_k,
	output logic [3:0]           rx_err,
	output logic                 rx_data,
	output logic                 cfg_bad,
	output logic                 swing_low,
	output logic [31:0]          err_count
);
	logic [3:0][2:0] lock;    // Consecutive K28.5 count per lane
	logic            sync_n;  // Registered sync request
	logic [2:0]      a_cnt;   // Lane 0 multiframe ends since release
	logic [30:0]     hist;    // Checker history, newest at bit zero
	logic [3:0]      errs;    // Mismatches in this symbol
	logic [9:0]      fk;

	// Decode against both disparities, expected one preferred
	function automatic logic [11:0] dec(input logic [9:0] s, input logic rd);
		logic [11:0] r;
		logic [10:0] e;
		logic [39:0] kl;
		r  = 12'h000;
		kl = {`JTFS_K_R, `JTFS_K_A, `JTFS_K_Q, `JTFS_K_K, `JTFS_K_F};
		for (int x = 1; x >= 0; x--) begin
			for (int i = 0; i < 256; i++) begin
				e = jtfs_enc(8'(i), 1'b0, rd ^ 1'(x));
				if (e[9:0] == s) r = {1'b1, 1'b0, 1'b0, e[10], 8'(i)};
			end
			for (int i = 0; i < 5; i++) begin
				e = jtfs_enc(kl[8 * i +: 8], 1'b1, rd ^ 1'(x));
				if (e[9:0] == s) r = {1'b1, 1'b1, 1'b0, e[10], kl[8 * i +: 8]};
			end
		end
		return r;
	endfunction

	// Same multiframe limits as the sender
	assign fk      = 10'({4'h0, cfg_k} << cfg_flog);
	assign cfg_bad = (fk < `JTFS_FK_MIN) || (fk > `JTFS_FK_MAX) || (fk[1:0] != 2'h0); // RULE19
	assign link.sync_n = sync_n;

	// Per lane decode and CGS lock
	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [11:0] d;
		logic        rd;
		assign d = dec(link.sym[l], rd);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				rd          <= 1'b0;
				lock[l]     <= 3'h0;
				rx_octet[l] <= 8'h00;
				rx_is_k[l]  <= 1'b0;
				rx_err[l]   <= 1'b0;
			end else begin
				rd          <= d[11] ? d[8] : rd;
				rx_octet[l] <= d[7:0];
				rx_is_k[l]  <= d[10];
				rx_err[l]   <= !d[11];
				// Lock count only matters while sync is held low
				if (!link_req) begin
					lock[l] <= 3'h0;
				end else if (sync_n) begin
					lock[l] <= lock[l];
				end else if (d[11] && d[10] && d[7:0] == `JTFS_K_K) begin
					lock[l] <= (lock[l] >= `JTFS_CGS_LOCK) ? lock[l] : lock[l] + 3'h1;
				end else begin
					lock[l] <= 3'h0;
				end
			end
		end
	end

	// Release sync once every lane is locked; user data after four /A/
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_n <= 1'b0;
			a_cnt  <= 3'h0;
		end else begin
			sync_n <= link_req && !cfg_bad && (lock[0] >= `JTFS_CGS_LOCK) &&
				(lock[1] >= `JTFS_CGS_LOCK) && (lock[2] >= `JTFS_CGS_LOCK) &&
				(lock[3] >= `JTFS_CGS_LOCK);
			if (!sync_n) begin
				a_cnt <= 3'h0;
			end else if (a_cnt < `JTFS_A_COUNT && rx_is_k[0] && rx_octet[0] == `JTFS_K_A) begin
				a_cnt <= a_cnt + 3'h1;
			end
		end
	end
	assign rx_data = (a_cnt >= `JTFS_A_COUNT);

	// Self-synchronizing checker on lane 0 raw bits
	always_comb begin
		logic [30:0] h;
		logic [9:0]  t;
		h    = hist;
		t    = jtfs_taps(chk_sel); // RULE15
		errs = 4'h0;
		for (int i = 9; i >= 0; i--) begin
			errs = errs + 4'(link.sym[0][i] != (h[t[9:5]] ^ h[t[4:0]]));
			h    = {h[29:0], link.sym[0][i]};
		end
	end

	// History, error count and swing watch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist      <= 31'h0000_0000;
			err_count <= 32'h0000_0000;
			swing_low <= 1'b0;
		end else begin
			hist      <= {hist[20:0], link.sym[0]};
			swing_low <= (link.swing < `JTFS_SWING_MIN); // RULE2
			if (chk_clear) begin
				err_count <= 32'h0000_0000; // RULE17
			end else if (chk_en) begin
				err_count <= err_count + {28'h0, errs}; // RULE17
			end
		end
	end
endmodule // jtfs_deframer

// ==== tb/jtfs_link_checker.sv ====
`timescale 1ns/1ps
module jtfs_link_checker (
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic [3:0][9:0] sym,
	input wire logic [3:0][9:0] boost,
	input wire logic [3:0]      swing,
	input wire logic [2:0]      emph,
	input wire logic            sync_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       comma; // Lane 0 shows K28.5, either disparity
	logic       arm;   // Sync granted, first ILAS symbol pending
	logic [2:0] run;   // Back to back commas, saturating
	assign comma = (sym[0] == 10'h0FA) || (sym[0] == 10'h305);
	// Any other symbol restarts the comma run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			run <= 3'h0;
		else if (!comma)
			run <= 3'h0;
		else if (run != 3'h7)
			run <= run + 3'h1;
	end
	// Armed from sync grant until the comma stream ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			arm <= 1'b0;
		else if ($rose(sync_n))
			arm <= 1'b1;
		else if (!comma)
			arm <= 1'b0;
	end
	swing_reset_a: assert property ($rose(hresetn) |-> swing == 4'hF)
		else $error("swing not fifteen after reset");
	sync_reset_a: assert property ($rose(hresetn) |-> !sync_n)
		else $error("sync request missing after reset");
	emph_off_a: assert property (emph == 3'h0 && $stable(emph) |-> boost == '0)
		else $error("boost while emphasis is off");
	// Boost lags the emphasis setting by one cycle, so only judge settled settings
	for (genvar p = 0; p < 4; p++) begin : g_lane
		boost_edge_a: assert property ($stable(emph) |->
			boost[p][8:0] == ((sym[p][8:0] ^ sym[p][9:1]) & {9{emph != 3'h0}}))
			else $error("boost differs from bit changes");
		boost_first_a: assert property ($stable(emph) && $past(hresetn) |->
			boost[p][9] == ((sym[p][9] != $past(sym[p][0])) && emph != 3'h0))
			else $error("boost on first bit wrong");
	end
	cgs_first_a: assert property ($rose(sync_n) |-> comma && run >= 3'h4)
		else $error("sync granted without comma run");
	ilas_start_a: assert property (arm && !comma |->
		sym[0] == 10'h0F4 || sym[0] == 10'h30B)
		else $error("alignment sequence not opened by start marker");
	cgs_exit_a: assert property ($rose(sync_n) |-> ##[1:300] !comma)
		else $error("comma stream outlived a multiframe");
	sync_up_c: cover property ($rose(sync_n));
	ilas_seen_c: cover property (arm && !comma);
	boost_seen_c: cover property (emph != 3'h0 && boost[0] != 10'h000);
endmodule // jtfs_link_checker

// ==== tb/jtfs_tb.sv ====
`timescale 1ns/1ps
`include "jtfs_cfg.svh"
module jtfs_tb;
	import jtfs_pkg::*;
	logic                  hclk = 1'b0;
	logic                  hresetn = 1'b0;
	logic                  hsel = 1'b0;
	logic [31:0]           haddr = 32'h0;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'b0;
	logic [2:0]            hsize = 3'h2;    // Whole words only
	logic [31:0]           hwdata = 32'h0;
	logic                  hreadyout;
	logic                  hresp;
	logic [31:0]           hrdata;
	logic [3:0][3:0][15:0] conv_sample = '0;
	logic                  link_req = 1'b0;
	logic [1:0]            cfg_flog = 2'h2; // F of four at reset layout
	logic [5:0]            cfg_k = 6'h20;
	logic                  chk_en = 1'b0;
	logic                  chk_clear = 1'b0;
	logic [2:0]            chk_sel = 3'h0;
	logic [3:0][7:0]       rx_octet;
	logic [3:0]            rx_is_k;
	logic [3:0]            rx_err;
	logic                  sample_take;
	logic                  rx_data;
	logic                  cfg_bad;
	logic                  swing_low;
	logic [31:0]           err_count;
	logic [31:0]           rd;              // Last read data
	logic [31:0]           lfsr = 32'h3944; // Stimulus source
	logic [31:0]           regm [5] = '{32'(`JTFS_CTRL_RST), 32'(`JTFS_FRAME_RST),
		32'(`JTFS_SERDES_RST), 32'(`JTFS_XBAR_RST), 32'h0};
	logic [31:0]           msk [5] = '{32'h1F, 32'hFFF, 32'h7F, 32'hFFFF, 32'h0};
	int                    n_mismatch = 0;
	int                    comparisons = 0;
	jtfs_link_if link ();
	jtfs_framer jtfs_framer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_sample(conv_sample),
		.sample_take(sample_take), .link(link));
	jtfs_deframer jtfs_deframer_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
		.link_req(link_req), .cfg_flog(cfg_flog), .cfg_k(cfg_k), .chk_en(chk_en),
		.chk_clear(chk_clear), .chk_sel(chk_sel), .rx_octet(rx_octet), .rx_is_k(rx_is_k),
		.rx_err(rx_err), .rx_data(rx_data), .cfg_bad(cfg_bad), .swing_low(swing_low),
		.err_count(err_count));
	jtfs_link_checker jtfs_link_checker_inst (.hclk(hclk), .hresetn(hresetn), .sym(link.sym),
		.boost(link.boost), .swing(link.swing), .emph(link.emph), .sync_n(link.sync_n));
	// Free running bus clock
	always #10 hclk = ~hclk;
	// Stimulus shift register step
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One cycle of a bounded wait; running out ends the run as a mismatch
	task automatic cycle_ok(input int n);
		if (n >= 2000) begin
			n_mismatch++;
			$display("[FAIL] wait expected done seen timeout");
			close_out();
		end else begin
			@(posedge hclk);
		end
	endtask
	// Single AHB transfer; address held until ready, data until ready again
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		for (n = 0; n == 0 || hreadyout !== 1'b1; n++) cycle_ok(n);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		for (n = 0; n == 0 || hreadyout !== 1'b1; n++) cycle_ok(n);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		regm[a[4:2]] = d & msk[a[4:2]];
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// Frame of two converters, one sample: MSB octet first, last octet replaced
	task automatic lane_chk(input int ln, input logic sw);
		logic [7:0] q [$];
		logic       prevk;
		int         n;
		int         c;
		for (c = 0; c < 2; c++) begin
			q.push_back(conv_sample[c ^ 32'(sw)][0][15:8]);
			q.push_back(conv_sample[c ^ 32'(sw)][0][7:0]);
		end
		prevk = 1'b0;
		// A frame start follows a replaced octet
		for (n = 0; !(prevk && rx_octet[ln] === q[0] && rx_is_k[ln] === 1'b0); n++) begin
			prevk = rx_is_k[ln];
			cycle_ok(n);
		end
		for (c = 1; c < 4; c++) begin
			@(posedge hclk);
			// Frame end leads the received octets by two cycles
			chk("sample_take", {31'h0, c == 1}, {31'h0, sample_take});
			chk("rx_err", 32'h0, {31'h0, rx_err[ln]});
			if (c < 3)
				chk("octet", {24'h0, q[c]}, {24'h0, rx_octet[ln]});
			else
				chk("frame_end", 32'h1, {31'h0, rx_is_k[ln] === 1'b1 &&
					(rx_octet[ln] == `JTFS_K_F || rx_octet[ln] == `JTFS_K_A)});
		end
	endtask
	initial begin
		int         i;
		int         f;
		logic       bad;
		int         tl [6] = '{2, 2, 0, 0, 0, 0};
		int         ts [6] = '{0, 0, 0, 0, 1, 1};
		int         tk [6] = '{30, 20, 4, 5, 32, 33};
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 5; i++) rchk("reset_reg", 8'(i * 4), regm[i]);
		rchk("unmapped", 8'h40, 32'h0);
		// Distinct octets so the frame order is visible
		for (i = 0; i < 16; i++) begin
			lfsr = nxt(lfsr);
			conv_sample[i / 4][i % 4] <= {2'(i / 4), lfsr[5:0], 2'(i / 4 + 2), lfsr[13:8]};
		end
		wr(`JTFS_ADDR_CTRL, 32'h1);
		link_req <= 1'b1;
		for (i = 0; rx_data !== 1'b1; i++) cycle_ok(i);
		rchk("status_data", `JTFS_ADDR_STATUS, 32'hA);
		lane_chk(0, 1'b0);
		wr(`JTFS_ADDR_XBAR, 32'hE1E0);
		// First swapped frame ends unlike the old one, so it is not replaced
		repeat (24) @(posedge hclk);
		lane_chk(1, 1'b1);
		for (i = 11; i < 16; i++) begin
			lfsr = nxt(lfsr);
			wr(`JTFS_ADDR_SERDES, 32'({lfsr[2:0], 4'(i)}));
			rchk("serdes", `JTFS_ADDR_SERDES, regm[2]);
			chk("swing_low", {31'h0, i < 12}, {31'h0, swing_low});
		end
		// Pattern runs with the link dropped; last pass uses a mismatched order
		link_req <= 1'b0;
		chk_en <= 1'b1;
		for (i = 0; i < 6; i++) begin
			wr(`JTFS_ADDR_CTRL, 32'(3 + 4 * (i % 5)));
			chk_sel <= 3'(i % 5 + i / 5);
			repeat (40) @(posedge hclk);
			chk_clear <= 1'b1;
			@(posedge hclk);
			chk_clear <= 1'b0;
			repeat (300) @(posedge hclk);
			chk("prbs_err", 32'(i / 5), {31'h0, err_count != 32'h0});
		end
		wr(`JTFS_ADDR_CTRL, 32'h1);
		rchk("status_cgs", `JTFS_ADDR_STATUS, 32'h0);
		for (i = 0; i < 6; i++) begin
			f = (4 << ts[i]) >> tl[i];
			bad = (f * tk[i] < 20) || (f * tk[i] > 256) || (f * tk[i] % 4 != 0);
			wr(`JTFS_ADDR_FRAME, 32'(tk[i] * 64 + ts[i] * 16 + tl[i] * 4 + 1));
			cfg_flog <= 2'(2 + ts[i] - tl[i]);
			cfg_k <= 6'(tk[i]);
			rchk("frame", `JTFS_ADDR_FRAME, regm[1]);
			chk("def_bad", {31'h0, bad}, {31'h0, cfg_bad});
			rchk("status_bad", `JTFS_ADDR_STATUS, {29'h0, bad, 2'h0});
		end
		close_out();
	end
endmodule // jtfs_tb
